// [design/fst_pkg.sv]
`default_nettype none
package fst_pkg;
  // Register byte offsets from the controller base
  localparam logic [7:0] OFS_FRAME_REMAINING = 8'h38;
  localparam logic [7:0] OFS_PERIODIC_START = 8'h40;
  localparam logic [7:0] OFS_LOW_SPEED = 8'h44;
  // Field widths, all fields start at bit 0
  localparam int FR_W = 14;
  localparam int PS_W = 14;
  localparam int LS_W = 12;
  localparam int PS_LSB = 0;
  localparam int LS_LSB = 0;
  localparam int FR_LSB = 0;
  // Values after reset
  localparam logic [13:0] PS_RESET = 14'h0000;
  localparam logic [11:0] LS_RESET = 12'h628;
  localparam logic [13:0] FR_RESET = 14'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;
  // Scheduling phase within one frame
  typedef enum logic [1:0] {
    SCH_NONPERIODIC,
    SCH_DRAIN_CB,
    SCH_PERIODIC
  } fst_sched_t;
endpackage
`default_nettype wire

// [design/fst_frame_counter.sv]
`timescale 1ns/1ns
`default_nettype none
module fst_frame_counter #(
  parameter int W = 14
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Bit timing and reload value
  input wire logic bit_tick_i,
  input wire logic [W-1:0] interval_i,
  // Counter state
  output logic [W-1:0] count_o,
  output logic reload_o
);
  logic [W-1:0] next_count;
  logic next_reload;

  always_comb begin
    next_count = count_o;
    next_reload = 1'b0;
    if (bit_tick_i) begin
      if (count_o == '0) begin
        next_count = interval_i;
        next_reload = 1'b1;
      end else begin
        next_count = count_o - W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= W'(fst_pkg::FR_RESET);
      reload_o <= 1'b0;
    end else if (ce_i) begin
      count_o <= next_count;
      reload_o <= next_reload;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_count_reload: assert property (ce_i && bit_tick_i && count_o == '0
      |=> count_o == $past(interval_i))
    else $error("Counter did not reload the interval at zero");
  a_count_step: assert property (ce_i && bit_tick_i && count_o != '0
      |=> count_o == $past(count_o) - W'(1))
    else $error("Counter did not step down by one");
  a_count_idle: assert property (!(ce_i && bit_tick_i) |=> $stable(count_o))
    else $error("Counter moved without a bit tick");
  c_reload: cover property (ce_i && bit_tick_i && count_o == '0);
endmodule
`default_nettype wire

// [design/fst_thresholds.sv]
`timescale 1ns/1ns
`default_nettype none
module fst_thresholds #(
  parameter int FR_W = fst_pkg::FR_W
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register access
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // Frame timing
  input wire logic bit_tick_i,
  input wire logic [FR_W-1:0] frame_interval_value_i,
  output logic [FR_W-1:0] frame_remaining_count_o,
  // List scheduling
  input wire logic ctl_bulk_busy_i,
  output logic periodic_priority_o,
  output logic interrupt_list_start_o,
  // Low-speed admission
  input wire logic ls_request_i,
  output logic ls_start_o,
  output logic ls_refused_o
);
  logic [fst_pkg::PS_W-1:0] periodic_start_threshold;
  logic [fst_pkg::LS_W-1:0] low_speed_limit_field;
  logic [fst_pkg::PS_W-1:0] next_ps;
  logic [fst_pkg::LS_W-1:0] next_lst;
  logic [31:0] next_rdata;
  fst_pkg::fst_sched_t sched;
  fst_pkg::fst_sched_t next_sched;
  logic next_int_start;
  logic next_ls_start;
  logic next_ls_refused;
  logic fr_reload;
  logic ps_reached;
  logic ls_fits;

  fst_frame_counter #(
    .W(FR_W)
  ) u_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .bit_tick_i(bit_tick_i),
    .interval_i(frame_interval_value_i),
    .count_o(frame_remaining_count_o),
    .reload_o(fr_reload)
  );

  // Decoding shared by the write and the read path
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Register file: reserved bits are not stored, so they always read zero
  always_comb begin
    next_ps = periodic_start_threshold;
    next_lst = low_speed_limit_field;
    next_rdata = reg_rdata_o;
    if (reg_wr_i && hit(reg_addr_i, fst_pkg::OFS_PERIODIC_START)) begin
      next_ps = reg_wdata_i[fst_pkg::PS_LSB +: fst_pkg::PS_W];
    end
    if (reg_wr_i && hit(reg_addr_i, fst_pkg::OFS_LOW_SPEED)) begin
      next_lst = reg_wdata_i[fst_pkg::LS_LSB +: fst_pkg::LS_W];
    end
    if (reg_rd_i) begin
      next_rdata = 32'h00000000;
      if (hit(reg_addr_i, fst_pkg::OFS_PERIODIC_START)) begin
        next_rdata[fst_pkg::PS_LSB +: fst_pkg::PS_W] = periodic_start_threshold;
      end else if (hit(reg_addr_i, fst_pkg::OFS_LOW_SPEED)) begin
        next_rdata[fst_pkg::LS_LSB +: fst_pkg::LS_W] = low_speed_limit_field;
      end else if (hit(reg_addr_i, fst_pkg::OFS_FRAME_REMAINING)) begin
        next_rdata[fst_pkg::FR_LSB +: FR_W] = frame_remaining_count_o;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periodic_start_threshold <= fst_pkg::PS_RESET;
      low_speed_limit_field <= fst_pkg::LS_RESET;
      reg_rdata_o <= fst_pkg::RDATA_RESET;
    end else if (ce_i) begin
      periodic_start_threshold <= next_ps;
      low_speed_limit_field <= next_lst;
      reg_rdata_o <= next_rdata;
    end
  end

  // Threshold crossing; less-or-equal also catches a threshold written late in a frame
  assign ps_reached = (frame_remaining_count_o <= FR_W'(periodic_start_threshold));
  assign ls_fits = (frame_remaining_count_o >= FR_W'(low_speed_limit_field));

  always_comb begin
    next_sched = sched;
    next_int_start = 1'b0;
    case (sched)
      fst_pkg::SCH_NONPERIODIC: begin
        if (!fr_reload && ps_reached) begin
          if (ctl_bulk_busy_i) begin
            next_sched = fst_pkg::SCH_DRAIN_CB;
          end else begin
            next_sched = fst_pkg::SCH_PERIODIC;
            next_int_start = 1'b1;
          end
        end
      end
      fst_pkg::SCH_DRAIN_CB: begin
        if (fr_reload) begin
          next_sched = fst_pkg::SCH_NONPERIODIC;
        end else if (!ctl_bulk_busy_i) begin
          next_sched = fst_pkg::SCH_PERIODIC;
          next_int_start = 1'b1;
        end
      end
      fst_pkg::SCH_PERIODIC: begin
        if (fr_reload) begin
          next_sched = fst_pkg::SCH_NONPERIODIC;
        end
      end
      default: begin
        next_sched = fst_pkg::SCH_NONPERIODIC;
      end
    endcase
  end

  // Low-speed admission is decided against the counter at the request cycle
  always_comb begin
    next_ls_start = ls_request_i && ls_fits;
    next_ls_refused = ls_request_i && !ls_fits;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sched <= fst_pkg::SCH_NONPERIODIC;
      periodic_priority_o <= 1'b0;
      interrupt_list_start_o <= 1'b0;
      ls_start_o <= 1'b0;
      ls_refused_o <= 1'b0;
    end else if (ce_i) begin
      sched <= next_sched;
      periodic_priority_o <= (next_sched != fst_pkg::SCH_NONPERIODIC);
      interrupt_list_start_o <= next_int_start;
      ls_start_o <= next_ls_start;
      ls_refused_o <= next_ls_refused;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_values: assert property (disable iff (1'b0)
      rst_i |=> periodic_start_threshold == fst_pkg::PS_RESET
      && low_speed_limit_field == fst_pkg::LS_RESET)
    else $error("Thresholds wrong after reset");
  a_ps_write: assert property (ce_i && reg_wr_i
      && reg_addr_i == fst_pkg::OFS_PERIODIC_START
      |=> periodic_start_threshold == $past(reg_wdata_i[fst_pkg::PS_LSB +: fst_pkg::PS_W]))
    else $error("Periodic threshold write lost");
  a_ls_write: assert property (ce_i && reg_wr_i
      && reg_addr_i == fst_pkg::OFS_LOW_SPEED
      |=> low_speed_limit_field == $past(reg_wdata_i[fst_pkg::LS_LSB +: fst_pkg::LS_W]))
    else $error("Low-speed limit write lost");

  // Read data is registered and must hold the value of the read edge, not a later write
  a_read_ps: assert property (ce_i && reg_rd_i
      && reg_addr_i == fst_pkg::OFS_PERIODIC_START
      |=> reg_rdata_o == {18'h00000, $past(periodic_start_threshold)})
    else $error("Periodic threshold read back wrong");
  a_read_ls: assert property (ce_i && reg_rd_i
      && reg_addr_i == fst_pkg::OFS_LOW_SPEED
      |=> reg_rdata_o == {20'h00000, $past(low_speed_limit_field)})
    else $error("Low-speed limit read back wrong");
  a_read_count: assert property (ce_i && reg_rd_i
      && reg_addr_i == fst_pkg::OFS_FRAME_REMAINING
      |=> reg_rdata_o[FR_W-1:0] == $past(frame_remaining_count_o))
    else $error("Frame counter read back wrong");
  a_rdata_hold: assert property (!(ce_i && reg_rd_i) |=> $stable(reg_rdata_o))
    else $error("Read data changed without a read");

  a_priority_on: assert property (ce_i && sched == fst_pkg::SCH_NONPERIODIC
      && !fr_reload && ps_reached |=> periodic_priority_o)
    else $error("Priority not raised at threshold");
  a_drain_hold: assert property (ce_i && sched == fst_pkg::SCH_DRAIN_CB
      && ctl_bulk_busy_i && !fr_reload |=> !interrupt_list_start_o && periodic_priority_o)
    else $error("Interrupt list started during control or bulk work");
  // A low clock enable leaves the start pulse standing one more cycle
  a_drain_done: assert property (ce_i && sched == fst_pkg::SCH_DRAIN_CB
      && !ctl_bulk_busy_i && !fr_reload
      |=> interrupt_list_start_o ##1 (!interrupt_list_start_o || !$past(ce_i)))
    else $error("Interrupt list not started after drain");
  a_start_single: assert property (ce_i && interrupt_list_start_o
      |=> !interrupt_list_start_o)
    else $error("Interrupt list start longer than one cycle");

  a_ls_admit: assert property (ce_i && ls_request_i && ls_fits
      |=> ls_start_o && !ls_refused_o)
    else $error("Low-speed start refused with room left");
  a_ls_refuse: assert property (ce_i && ls_request_i
      && frame_remaining_count_o < FR_W'(low_speed_limit_field)
      |=> !ls_start_o && ls_refused_o)
    else $error("Low-speed start granted too late in frame");
  a_ls_idle: assert property (ce_i && !ls_request_i
      |=> !ls_start_o && !ls_refused_o)
    else $error("Low-speed answer without a request");

  a_priority_hold: assert property (ce_i && periodic_priority_o && !fr_reload
      |=> periodic_priority_o)
    else $error("Priority dropped before frame reload");
  a_priority_end: assert property (ce_i && fr_reload |=> !periodic_priority_o)
    else $error("Priority kept over the frame reload");
  a_reload_no_start: assert property (ce_i && fr_reload |=> !interrupt_list_start_o)
    else $error("Interrupt list started on the frame reload");

  c_direct_periodic: cover property (sched == fst_pkg::SCH_NONPERIODIC
      ##1 sched == fst_pkg::SCH_PERIODIC);
  c_drain_then_periodic: cover property (sched == fst_pkg::SCH_DRAIN_CB
      ##[1:20] interrupt_list_start_o);
  c_ls_refused: cover property (ls_refused_o);
  c_ls_started: cover property (ls_start_o);
endmodule
`default_nettype wire

// [verif/fst_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fst_host_model (
  // Clock and read data
  input wire logic clk_i,
  input wire logic [31:0] reg_rdata_i,
  // Register access
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [31:0] reg_wdata_o
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 32'h00000000;
  end
  // Released lines are inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [13:0] v);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = (a == fst_pkg::OFS_LOW_SPEED) ? {20'h00000, v[11:0]} : {18'h00000, v};
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    d = reg_rdata_i;
  endtask
  task automatic init(input logic [13:0] fi, input logic [13:0] tx, input logic [13:0] su);
    wr(fst_pkg::OFS_PERIODIC_START, fi / 14'd10);
    wr(fst_pkg::OFS_LOW_SPEED, tx + su);
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] a; logic [13:0] v; logic [31:0] e;} fst_row_t;
  fst_row_t rows [7] = '{'{8'h40, 14'h3e67, 32'h3e67}, '{8'h44, 14'h0abc, 32'h0abc},
    '{8'h40, 14'h3fff, 32'h3fff}, '{8'h44, 14'h0fff, 32'h0fff}, '{8'h40, 14'h1, 32'h1},
    '{8'h48, 14'h1234, 32'h0}, '{8'h38, 14'h5, 32'h0}};
  logic clk = 1'b0;
  logic rst, ce, tick, busy, req, mon, vq, rq, tq, wr, rd, prio, ils, lss, lsr;
  logic [7:0] addr;
  logic [13:0] fi, cq, c, cnt;
  logic [31:0] r, k, wdata, rdata;
  int n_fail = 0;
  int checks = 0;
  always #5 clk = ~clk;
  fst_host_model host (.clk_i(clk), .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata));
  fst_thresholds dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .bit_tick_i(tick),
    .frame_interval_value_i(fi), .frame_remaining_count_o(cnt), .ctl_bulk_busy_i(busy),
    .periodic_priority_o(prio), .interrupt_list_start_o(ils), .ls_request_i(req),
    .ls_start_o(lss), .ls_refused_o(lsr));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic conclude;
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Bounded so a stuck counter cannot hang the run
  task automatic wait_cnt(input logic [13:0] v);
    int n;
    n = 0;
    @(negedge clk);
    while (cnt !== v && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk({18'h0, cnt}, {18'h0, v});
  endtask
  // Cycle-by-cycle reference for the counter and low-speed admission, limit 20
  always @(posedge clk) begin
    cq <= cnt;
    rq <= req;
    tq <= tick;
    vq <= mon & ce & ~rst;
  end
  always @(negedge clk) begin
    if (vq) begin
      chk({18'h0, cnt}, {18'h0, tq ? ((cq == 14'h0) ? fi : cq - 14'h1) : cq});
      chk({31'h0, lss}, {31'h0, rq && cq >= 14'd20});
      chk({31'h0, lsr}, {31'h0, rq && cq < 14'd20});
    end
  end
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    tick = 1'b0;
    busy = 1'b0;
    req = 1'b0;
    mon = 1'b0;
    fi = 14'd100;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk({prio, ils, lss, lsr, 14'h0, cnt}, 32'h0);
    host.rd(8'h40, r);
    chk(r, 32'h0);
    host.rd(8'h44, r);
    chk(r, 32'h628);
    for (int i = 0; i < 7; i++) begin
      host.wr(rows[i].a, rows[i].v);
      host.rd(rows[i].a, r);
      chk(r, rows[i].e);
    end
    host.init(fi, 14'd12, 14'd8);
    tick = 1'b1;
    req = 1'b1;
    mon = 1'b1;
    wait_cnt(14'd10);
    chk({31'h0, prio}, 32'h0);
    @(negedge clk);
    chk({30'h0, prio, ils}, 32'h3);
    @(negedge clk);
    chk({31'h0, ils}, 32'h0);
    wait_cnt(fi);
    chk({31'h0, prio}, 32'h1);
    @(negedge clk);
    chk({31'h0, prio}, 32'h0);
    busy = 1'b1;
    wait_cnt(14'd10);
    k = 32'h0;
    repeat (4) begin
      @(negedge clk);
      k = k + ils;
    end
    chk({k[30:0], prio}, 32'h1);
    busy = 1'b0;
    repeat (3) begin
      @(negedge clk);
      k = k + ils;
    end
    chk(k, 32'h1);
    ce = 1'b0;
    c = cnt;
    repeat (3) @(negedge clk);
    chk({18'h0, cnt}, {18'h0, c});
    ce = 1'b1;
    tick = 1'b0;
    repeat (3) @(negedge clk);
    host.rd(8'h38, r);
    chk(r, {18'h0, c});
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk({prio, ils, lss, lsr, 14'h0, cnt}, 32'h0);
    host.rd(8'h40, r);
    chk(r, 32'h0);
    host.rd(8'h44, r);
    chk(r, 32'h628);
    conclude();
  end
endmodule
`default_nettype wire
